//--- shared/pfs_pkg.sv
package pfs_pkg;
    // register addresses
    localparam logic [4:0] PFS_ADDR_PIPE3_W  = 5'h14;
    localparam logic [4:0] PFS_ADDR_PIPE4_W  = 5'h15;
    localparam logic [4:0] PFS_ADDR_PIPE5_W  = 5'h16;
    localparam logic [4:0] PFS_ADDR_QSTATE   = 5'h17;
    localparam logic [4:0] PFS_ADDR_VAR_LEN  = 5'h1c;

    // field layout
    localparam int         PFS_LEN_W        = 6;
    localparam int         PFS_PAY_W        = 256;
    localparam int         PFS_NPIPE        = 6;
    localparam int         PFS_NWIDTH       = 3;
    localparam int         PFS_ST_REUSE     = 6;
    localparam int         PFS_ST_TX_FULL   = 5;
    localparam int         PFS_ST_TX_EMPTY  = 4;
    localparam int         PFS_ST_RX_FULL   = 1;
    localparam int         PFS_ST_RX_EMPTY  = 0;

    // reset values and queue figures
    localparam logic [7:0] PFS_STATUS_RST   = 8'h11;
    localparam logic [1:0] PFS_PTR_LAST     = 2'h2;
    localparam logic [1:0] PFS_CNT_FULL     = 2'h3;
    localparam logic [1:0] PFS_CNT_EMPTY    = 2'h0;

    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } pfs_reg_req_t;

    typedef struct packed {
        logic tx_write;
        logic resend;
        logic flush_tx;
        logic flush_rx;
        logic rx_pop;
    } pfs_cmd_t;

    typedef struct packed {
        logic [PFS_LEN_W-1:0] len;
        logic [PFS_PAY_W-1:0] data;
    } pfs_pkt_t;

    typedef struct packed {
        pfs_pkt_t [2:0]                   tx_mem;
        logic [1:0]                       tx_rd;
        logic [1:0]                       tx_wr;
        logic [1:0]                       tx_cnt;
        pfs_pkt_t [2:0]                   rx_mem;
        logic [1:0]                       rx_rd;
        logic [1:0]                       rx_wr;
        logic [1:0]                       rx_cnt;
        pfs_pkt_t                         last;
        logic                             reuse;
        logic [PFS_NWIDTH-1:0][PFS_LEN_W-1:0] width;
        logic [PFS_NPIPE-1:0]             var_len;
        logic [1:0]                       ce_sync;
        logic [7:0]                       rdata;
        logic [7:0]                       status;
        pfs_pkt_t                         tx_out;
        pfs_pkt_t                         rx_out;
        logic                             tx_go;
        logic                             resend;
        logic [PFS_NPIPE-1:0]             var_eff;
    } pfs_state_t;
endpackage

//--- hdl/pfs_regs.sv
`timescale 1ns/1ns
module pfs_regs
    import pfs_pkg::*;
(
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            resetn,
    // register access and commands from the command decoder
    input  wire pfs_reg_req_t                    reg_req,
    input  wire pfs_cmd_t                        cmd,
    input  wire pfs_pkt_t                        tx_pkt_in,
    output logic [7:0]                           reg_rdata,
    output pfs_pkt_t                             rx_pkt,
    // radio engine side
    input  wire logic                            ce_pin,
    input  wire logic                            tx_done,
    input  wire logic                            rx_store,
    input  wire pfs_pkt_t                        rx_pkt_in,
    input  wire logic                            feature_var_len,
    input  wire logic [PFS_NPIPE-1:0]            auto_ack_enable,
    output pfs_pkt_t                             tx_pkt,
    output logic                                 tx_go,
    output logic                                 tx_resend,
    output logic [7:0]                           queue_status,
    output logic [PFS_NWIDTH-1:0][PFS_LEN_W-1:0] pipe_width,
    output logic [PFS_NPIPE-1:0]                 var_len_active
);
    pfs_state_t q;
    pfs_state_t d;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       rx_pop;

    function automatic logic [1:0] nxt(input logic [1:0] p);
        nxt = (p == PFS_PTR_LAST) ? 2'h0 : p + 2'h1;
    endfunction

    always_comb begin
        d = q;
        d.ce_sync = {q.ce_sync[0], ce_pin};
        // register writes; queue flags take no writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                PFS_ADDR_PIPE3_W: d.width[0] = reg_req.wdata[PFS_LEN_W-1:0];
                PFS_ADDR_PIPE4_W: d.width[1] = reg_req.wdata[PFS_LEN_W-1:0];
                PFS_ADDR_PIPE5_W: d.width[2] = reg_req.wdata[PFS_LEN_W-1:0];
                PFS_ADDR_VAR_LEN: d.var_len  = reg_req.wdata[PFS_NPIPE-1:0];
                default: d.var_len = q.var_len;
            endcase
        end
        // transmit queue; a held packet is not consumed while reuse stands
        tx_pop  = tx_done && !q.reuse && (q.tx_cnt != PFS_CNT_EMPTY);
        tx_push = cmd.tx_write && (q.tx_cnt != PFS_CNT_FULL);
        if (tx_pop) begin
            d.last  = q.tx_mem[q.tx_rd];
            d.tx_rd = nxt(q.tx_rd);
        end
        if (tx_push) begin
            d.tx_mem[q.tx_wr] = tx_pkt_in;
            d.tx_wr           = nxt(q.tx_wr);
        end
        d.tx_cnt = q.tx_cnt + 2'(tx_push) - 2'(tx_pop);
        if (cmd.flush_tx) begin
            d.tx_rd  = 2'h0;
            d.tx_wr  = 2'h0;
            d.tx_cnt = PFS_CNT_EMPTY;
        end
        // reuse flag: a resend in the same cycle as a clear wins
        if (cmd.tx_write || cmd.flush_tx) begin
            d.reuse = 1'b0;
        end
        if (cmd.resend) begin
            d.reuse = 1'b1;
        end
        // receive queue, shared by all pipes
        rx_pop  = cmd.rx_pop && (q.rx_cnt != PFS_CNT_EMPTY);
        rx_push = rx_store && (q.rx_cnt != PFS_CNT_FULL);
        if (rx_pop) begin
            d.rx_rd = nxt(q.rx_rd);
        end
        if (rx_push) begin
            d.rx_mem[q.rx_wr] = rx_pkt_in;
            d.rx_wr           = nxt(q.rx_wr);
        end
        d.rx_cnt = q.rx_cnt + 2'(rx_push) - 2'(rx_pop);
        if (cmd.flush_rx) begin
            d.rx_rd  = 2'h0;
            d.rx_wr  = 2'h0;
            d.rx_cnt = PFS_CNT_EMPTY;
        end
        // queue state
        d.status                  = 8'h00;
        d.status[PFS_ST_REUSE]    = d.reuse;
        d.status[PFS_ST_TX_FULL]  = (d.tx_cnt == PFS_CNT_FULL);
        d.status[PFS_ST_TX_EMPTY] = (d.tx_cnt == PFS_CNT_EMPTY);
        d.status[PFS_ST_RX_FULL]  = (d.rx_cnt == PFS_CNT_FULL);
        d.status[PFS_ST_RX_EMPTY] = (d.rx_cnt == PFS_CNT_EMPTY);
        // read data for the current address, reserved bits zero
        case (reg_req.addr)
            PFS_ADDR_PIPE3_W: d.rdata = {2'h0, q.width[0]};
            PFS_ADDR_PIPE4_W: d.rdata = {2'h0, q.width[1]};
            PFS_ADDR_PIPE5_W: d.rdata = {2'h0, q.width[2]};
            PFS_ADDR_QSTATE:  d.rdata = q.status;
            PFS_ADDR_VAR_LEN: d.rdata = {2'h0, q.var_len};
            default:          d.rdata = 8'h00;
        endcase
        d.tx_out  = d.reuse ? d.last : d.tx_mem[d.tx_rd];
        d.rx_out  = d.rx_mem[d.rx_rd];
        d.tx_go   = q.ce_sync[1] && (d.reuse || (d.tx_cnt != PFS_CNT_EMPTY));
        d.resend  = q.ce_sync[1] && d.reuse;
        d.var_eff = d.var_len & auto_ack_enable & {PFS_NPIPE{feature_var_len}};
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q        <= '0;
            q.status <= PFS_STATUS_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata      = q.rdata;
    assign rx_pkt         = q.rx_out;
    assign tx_pkt         = q.tx_out;
    assign tx_go          = q.tx_go;
    assign tx_resend      = q.resend;
    assign queue_status   = q.status;
    assign pipe_width     = q.width;
    assign var_len_active = q.var_eff;

    a_tx_full_hold: assert property (@(posedge clock) disable iff (!resetn)
        (q.tx_cnt == PFS_CNT_FULL && cmd.tx_write && !cmd.flush_tx && !tx_done)
        |=> q.status[PFS_ST_TX_FULL] && $stable(q.tx_cnt))
        else $error("push into full transmit queue changed it");
    a_tx_empty_flag: assert property (@(posedge clock) disable iff (!resetn)
        cmd.flush_tx |=> q.status[PFS_ST_TX_EMPTY] && !q.status[PFS_ST_TX_FULL])
        else $error("transmit flush did not empty queue");
    a_rx_full_flag: assert property (@(posedge clock) disable iff (!resetn)
        (q.rx_cnt == PFS_CNT_EMPTY && rx_store && !cmd.flush_rx && !cmd.rx_pop)
        ##1 (rx_store && !cmd.flush_rx && !cmd.rx_pop) [*2]
        |=> q.status[PFS_ST_RX_FULL] && !q.status[PFS_ST_RX_EMPTY])
        else $error("three stores did not fill receive queue");
    a_rx_empty_pop: assert property (@(posedge clock) disable iff (!resetn)
        (q.rx_cnt == 2'h1 && cmd.rx_pop && !rx_store) |=> q.status[PFS_ST_RX_EMPTY])
        else $error("last receive pop did not show empty");
    a_reuse_set: assert property (@(posedge clock) disable iff (!resetn)
        cmd.resend |=> q.status[PFS_ST_REUSE])
        else $error("resend command did not set reuse");
    a_reuse_clear: assert property (@(posedge clock) disable iff (!resetn)
        (!cmd.resend && (cmd.tx_write || cmd.flush_tx)) |=> !q.reuse)
        else $error("reuse not cleared by write or flush");
    a_resend_level: assert property (@(posedge clock) disable iff (!resetn)
        (q.reuse && q.ce_sync[1] && !cmd.tx_write && !cmd.flush_tx) |=> tx_resend && tx_go)
        else $error("resend not driven while reuse and enable high");
    a_reuse_keep: assert property (@(posedge clock) disable iff (!resetn)
        (q.reuse && tx_done && !cmd.tx_write && !cmd.flush_tx) |=> $stable(q.tx_cnt) && $stable(q.last))
        else $error("reused packet consumed");
    a_var_len_gate: assert property (@(posedge clock) disable iff (!resetn)
        !feature_var_len |=> var_len_active == '0)
        else $error("variable length active without feature bit");
    a_flag_writes: assert property (@(posedge clock) disable iff (!resetn)
        (reg_req.wr && reg_req.addr == PFS_ADDR_QSTATE && !tx_done && !rx_store && cmd == '0)
        |=> $stable(q.tx_cnt) && $stable(q.rx_cnt) && $stable(q.reuse))
        else $error("write to queue state changed flags");
    a_width_read: assert property (@(posedge clock) disable iff (!resetn)
        (!reg_req.wr && reg_req.addr == PFS_ADDR_PIPE3_W) |=> reg_rdata == {2'h0, $past(q.width[0])})
        else $error("width read back wrong");
    a_rx_full_drop: assert property (@(posedge clock) disable iff (!resetn)
        (q.rx_cnt == PFS_CNT_FULL && rx_store && !cmd.rx_pop && !cmd.flush_rx)
        |=> $stable(q.rx_cnt) && q.status[PFS_ST_RX_FULL])
        else $error("store into full receive queue changed it");
    a_tx_pop_step: assert property (@(posedge clock) disable iff (!resetn)
        (!q.reuse && tx_done && q.tx_cnt != PFS_CNT_EMPTY && !cmd.tx_write && !cmd.flush_tx && !cmd.resend)
        |=> q.tx_cnt == $past(q.tx_cnt) - 2'h1)
        else $error("sent packet not taken from transmit queue");
    a_go_needs_ce: assert property (@(posedge clock) disable iff (!resetn)
        !q.ce_sync[1] |=> !tx_go && !tx_resend)
        else $error("transmit driven without chip enable");
endmodule

//--- tb/pfs_host_model.sv
`timescale 1ns/1ns
module pfs_host_model
#(
    parameter int CE_MIN = 2500
)
(
    // bench control
    input  wire logic clock,
    input  wire logic start,
    // chip enable pin
    output logic      ce_pin
);
    int cnt = 0;

    // enable pulse never shorter than the minimum width
    always @(posedge clock) begin
        if (start) begin
            cnt <= CE_MIN;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign ce_pin = (cnt != 0);
endmodule

//--- tb/pfs_regs_tb.sv
`timescale 1ns/1ns
module pfs_regs_tb;
    import pfs_pkg::*;
    logic                            clock = 1'b0, resetn = 1'b0, ce_start = 1'b0, ce_pin;
    logic                            tx_done = 1'b0, rx_store = 1'b0, feat = 1'b0, rd = 1'b0, rd_q = 1'b0;
    logic [5:0]                      ack = '0;
    logic [7:0]                      v, rdata, status;
    pfs_reg_req_t                    req = '0;
    pfs_cmd_t                        cmd = '0;
    pfs_pkt_t                        pin = '0, rin = '0, tx_pkt, rx_pkt;
    logic                            tx_go, tx_resend;
    logic [PFS_NWIDTH-1:0][PFS_LEN_W-1:0] widths;
    logic [PFS_NPIPE-1:0]            vl_act;
    logic [7:0]                      expq[$];
    pfs_pkt_t                        txp[4], rxp[4];
    int                              fails = 0, checked = 0;

    always #2 clock = ~clock;

    pfs_regs DUT (.clock(clock), .resetn(resetn), .reg_req(req), .cmd(cmd), .tx_pkt_in(pin),
        .reg_rdata(rdata), .rx_pkt(rx_pkt), .ce_pin(ce_pin), .tx_done(tx_done), .rx_store(rx_store),
        .rx_pkt_in(rin), .feature_var_len(feat), .auto_ack_enable(ack), .tx_pkt(tx_pkt), .tx_go(tx_go),
        .tx_resend(tx_resend), .queue_status(status), .pipe_width(widths), .var_len_active(vl_act));
    pfs_host_model #(.CE_MIN(2500)) host (.clock(clock), .start(ce_start), .ce_pin(ce_pin));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pkt(input pfs_pkt_t got, input pfs_pkt_t exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // read data lands one cycle after the address
    always @(posedge clock) begin
        rd_q <= rd;
        if (rd_q) begin
            cmp(rdata, expq.pop_front());
        end
    end

    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        req.wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd8(input logic [4:0] a, input logic [7:0] e);
        req.addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic pulse(input pfs_cmd_t c);
        cmd <= c;
        @(posedge clock);
        cmd <= '0;
        @(posedge clock);
    endtask
    task automatic results;
        $display("counts: checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        fails++;
        results();
    end

    initial begin
        void'($urandom(32'h199d70ef));
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rd8(PFS_ADDR_PIPE5_W, 8'h00);
        rd8(PFS_ADDR_QSTATE, 8'h11);
        rd8(5'h00, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            v = i == 0 ? 8'he0 : 8'($urandom());
            wr8(PFS_ADDR_PIPE3_W + 5'(i), v);
            rd8(PFS_ADDR_PIPE3_W + 5'(i), v & 8'h3f);
            cmp({2'h0, widths[i]}, v & 8'h3f);
        end
        v = 8'($urandom()) | 8'hc0;
        wr8(PFS_ADDR_VAR_LEN, v);
        rd8(PFS_ADDR_VAR_LEN, v & 8'h3f);
        wr8(PFS_ADDR_QSTATE, 8'hff);
        rd8(PFS_ADDR_QSTATE, 8'h11);
        for (int i = 0; i < 4; i++) begin
            feat <= i[0];
            ack <= i[1] ? 6'h3f : 6'($urandom());
            repeat (3) @(posedge clock);
            #1 cmp({2'h0, vl_act}, {2'h0, v[5:0] & ack & {6{feat}}});
            @(posedge clock);
        end
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            txp[i] = {6'(1 + $urandom_range(31)), {8{$urandom()}}};
            pin <= txp[i];
            pulse('{tx_write: 1'b1, default: 1'b0});
            cmp_pkt(tx_pkt, txp[0]);
            rd8(PFS_ADDR_QSTATE, i < 2 ? 8'h01 : 8'h21);
        end
        pulse('{resend: 1'b1, default: 1'b0});
        rd8(PFS_ADDR_QSTATE, 8'h61);
        ce_start <= 1'b1;
        @(posedge clock);
        ce_start <= 1'b0;
        repeat (5) @(posedge clock);
        #1 cmp({6'h0, tx_go, tx_resend}, 8'h03);
        @(posedge clock);
        tx_done <= 1'b1;
        @(posedge clock);
        tx_done <= 1'b0;
        @(posedge clock);
        rd8(PFS_ADDR_QSTATE, 8'h61);
        pulse('{flush_tx: 1'b1, default: 1'b0});
        rd8(PFS_ADDR_QSTATE, 8'h11);
        pulse('{tx_write: 1'b1, default: 1'b0});
        pulse('{resend: 1'b1, default: 1'b0});
        rd8(PFS_ADDR_QSTATE, 8'h41);
        pulse('{tx_write: 1'b1, default: 1'b0});
        rd8(PFS_ADDR_QSTATE, 8'h01);
        $display("transmit queue done");
        for (int i = 0; i < 4; i++) begin
            rxp[i] = {6'(1 + $urandom_range(31)), {8{$urandom()}}};
            rin <= rxp[i];
            rx_store <= 1'b1;
            @(posedge clock);
            rx_store <= 1'b0;
            @(posedge clock);
            rd8(PFS_ADDR_QSTATE, i < 2 ? 8'h00 : 8'h02);
        end
        cmp_pkt(rx_pkt, rxp[0]);
        for (int i = 0; i < 4; i++) begin
            pulse('{rx_pop: 1'b1, default: 1'b0});
            if (i < 2) cmp_pkt(rx_pkt, rxp[i + 1]);
            rd8(PFS_ADDR_QSTATE, i < 2 ? 8'h00 : 8'h01);
        end
        $display("receive queue done");
        repeat (2) @(posedge clock);
        results();
    end
endmodule
